/* shared/alu_pkg.sv */
/*
 * Shared constants for the data ALU: widths, status bit positions,
 * operation and register codes.
 * Assumes the sequencer drives codes from these enumerations.
 */
package alu_pkg;
  localparam int WORD_W = 24;
  localparam int ACC_W = 56;
  localparam int SHIFT_NORMAL = 24;
  localparam int SHIFT_SIXTEEN = 16;
  localparam int SR_W = 24;
  localparam int SR_DPM_POS = 14;
  localparam int MR_DPM_POS = 6;
  localparam int SR_GROWTH_POS = 7;
  localparam int SR_SIXTEEN_POS = 17;
  localparam logic [55:0] SIXTEEN_MASK = 56'hFF_FFFF00_FFFF00;
  localparam logic [23:0] WORD_RST = 24'h000000;
  localparam logic [55:0] ACC_RST = 56'h00_000000_000000;

  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_MPY = 3'b001,
    OP_MAC = 3'b010,
    OP_SHMAC = 3'b011,
    OP_DPSTEP = 3'b100
  } op_type;

  typedef enum logic [1:0] {
    SG_SS = 2'b00,
    SG_SU = 2'b01,
    SG_UU = 2'b10
  } sign_type;

  typedef enum logic [3:0] {
    R_X0 = 4'h0, R_X1 = 4'h1, R_Y0 = 4'h2, R_Y1 = 4'h3,
    R_A0 = 4'h4, R_A1 = 4'h5, R_A2 = 4'h6,
    R_B0 = 4'h7, R_B1 = 4'h8, R_B2 = 4'h9,
    R_A = 4'hA, R_B = 4'hB, R_X = 4'hC, R_Y = 4'hD,
    R_A10 = 4'hE, R_B10 = 4'hF
  } reg_type;
endpackage

/* verilog/mul_unit.sv */
/*
 * Mixed-sign 24 x 24 multiplier giving a signed 50-bit product.
 * Assumes operand signedness is chosen per operation by the caller.
 */
`timescale 1ns/10ps
module mul_unit #(
  parameter int W = 24
) (
  input wire logic [W-1:0] op_a,
  input wire logic [W-1:0] op_b,
  input wire logic a_signed,
  input wire logic b_signed,
  output logic [2*W+1:0] prod
);
  // ****************************************************
  // Extend each operand by one bit so unsigned fits too
  // ****************************************************
  logic signed [W:0] ext_a;
  logic signed [W:0] ext_b;
  assign ext_a = $signed({a_signed & op_a[W-1], op_a});
  assign ext_b = $signed({b_signed & op_b[W-1], op_b});
  assign prod = ext_a * ext_b;
endmodule // mul_unit

/* verilog/data_alu.sv */
/*
 * Data ALU core: input registers, two accumulators, mixed-sign
 * multiply, shifted accumulate, double precision mode, sixteen bit
 * mode and the sticky growth flag.
 * Assumes the sequencer issues one operation and one move per cycle
 * on clk_sys and keeps the program restrictions of the modes.
 */
`timescale 1ns/10ps
module data_alu #(
  parameter int W = 24
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [alu_pkg::SR_W-1:0] status_register,
  input wire logic growth_clr,
  input wire alu_pkg::op_type op_code,
  input wire alu_pkg::sign_type op_sign,
  input wire logic [1:0] op_src1,
  input wire logic [1:0] op_src2,
  input wire logic op_dst_b,
  input wire logic [1:0] dp_step,
  input wire logic move_wr,
  input wire alu_pkg::reg_type move_wr_reg,
  input wire logic [W-1:0] x_data_bus,
  input wire logic [W-1:0] y_data_bus,
  input wire logic move_rd,
  input wire alu_pkg::reg_type move_rd_reg,
  output logic [W-1:0] x_bus_out_ff,
  output logic [W-1:0] y_bus_out_ff,
  output logic growth_flag_ff,
  output logic dpm_active_ff,
  output logic sixteen_active_ff,
  output logic [alu_pkg::ACC_W-1:0] acc_a_ff,
  output logic [alu_pkg::ACC_W-1:0] acc_b_ff
);
  // ****************************************************
  // Register file
  // ****************************************************
  logic [W-1:0] x0_ff, x1_ff, shared_operand_reg_ff, y1_ff;
  logic [W-1:0] mul_a, mul_b, nxt_x, nxt_y;
  logic [2*W+1:0] prod;
  logic a_sg, b_sg, shift_en, acc_en, op_go;
  // Width of a sixteen bit mode result: guard, high and low parts
  localparam int N_W = alu_pkg::ACC_W - alu_pkg::SHIFT_SIXTEEN;
  logic [alu_pkg::ACC_W-1:0] acc_old, addend, prod_ext, nxt_acc;
  logic [N_W-1:0] acc_40, addend_40, prod_40, sum_40;

  // Operand fetch; low byte read as zero in sixteen bit mode
  function automatic logic [W-1:0] fetch(input logic [1:0] sel,
      input logic [W-1:0] r0, input logic [W-1:0] r1,
      input logic [W-1:0] r2, input logic [W-1:0] r3,
      input logic sa);
    logic [W-1:0] v;
    v = (sel == 2'd0) ? r0 : (sel == 2'd1) ? r1 :
        (sel == 2'd2) ? r2 : r3;
    fetch = sa ? {v[W-1:8], 8'h00} : v;
  endfunction

  // Word written from a bus: sixteen bit data lands in the top 16 bits
  function automatic logic [W-1:0] wr_word(input logic [W-1:0] d,
      input logic sa);
    wr_word = sa ? {d[15:0], 8'h00} : d;
  endfunction

  // Word read onto a bus: top 16 bits go to the low end, zero filled
  function automatic logic [W-1:0] rd_word(input logic [W-1:0] r,
      input logic sa);
    rd_word = sa ? {8'h00, r[W-1:8]} : r;
  endfunction

  // Growth to quarter scale or beyond of a value moved off a full accumulator
  function automatic logic grows(input logic [alu_pkg::ACC_W-1:0] acc);
    grows = (acc[46] != acc[47]) || (acc[45] != acc[47]);
  endfunction

  // Sixteen bit mode: the two 16-bit parts form one continuous number
  function automatic logic [N_W-1:0] pack16(
      input logic [alu_pkg::ACC_W-1:0] a);
    pack16 = {a[55:32], a[23:8]};
  endfunction

  function automatic logic [alu_pkg::ACC_W-1:0] unpack16(
      input logic [N_W-1:0] v);
    unpack16 = {v[39:16], 8'h00, v[15:0], 8'h00};
  endfunction

  // ****************************************************
  // Mode bits; one cycle of pipeline delay on each
  // ****************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dpm_active_ff <= 1'b0;
    end else begin
      dpm_active_ff <=
        status_register[alu_pkg::SR_DPM_POS];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sixteen_active_ff <= 1'b0;
    end else begin
      // The program keeps two quiet cycles around the switch
      sixteen_active_ff <=
        status_register[alu_pkg::SR_SIXTEEN_POS];
    end
  end

  // ****************************************************
  // Multiply and accumulate datapath
  // ****************************************************
  always_comb begin
    mul_a = fetch(op_src1, x0_ff, x1_ff, shared_operand_reg_ff, y1_ff,
                  sixteen_active_ff);
    mul_b = fetch(op_src2, x0_ff, x1_ff, shared_operand_reg_ff, y1_ff,
                  sixteen_active_ff);
    a_sg = (op_sign != alu_pkg::SG_UU);
    b_sg = (op_sign == alu_pkg::SG_SS);
    acc_en = (op_code == alu_pkg::OP_MAC);
    shift_en = (op_code == alu_pkg::OP_SHMAC);
    op_go = (op_code == alu_pkg::OP_MPY) || acc_en || shift_en;
    // Other ops while the mode runs are the program's fault; dropped
    if (dpm_active_ff) begin
      op_go = 1'b0;
    end
    if (op_code == alu_pkg::OP_DPSTEP && dpm_active_ff &&
        !sixteen_active_ff) begin
      op_go = 1'b1;
      // Steps 0 and 1 read the shared operand register, so it must hold
      case (dp_step)
        2'd0: begin
          mul_a = x0_ff; mul_b = shared_operand_reg_ff;
          a_sg = 1'b0; b_sg = 1'b0; acc_en = 1'b0; shift_en = 1'b0;
        end
        2'd1: begin
          mul_a = x1_ff; mul_b = shared_operand_reg_ff;
          a_sg = 1'b1; b_sg = 1'b0; acc_en = 1'b0; shift_en = 1'b1;
        end
        2'd2: begin
          mul_a = y1_ff; mul_b = x0_ff;
          a_sg = 1'b1; b_sg = 1'b0; acc_en = 1'b1; shift_en = 1'b0;
        end
        default: begin
          mul_a = x1_ff; mul_b = y1_ff;
          a_sg = 1'b1; b_sg = 1'b1; acc_en = 1'b0; shift_en = 1'b1;
        end
      endcase
    end
  end

  mul_unit #(.W(W)) u_mul (
    .op_a(mul_a),
    .op_b(mul_b),
    .a_signed(a_sg),
    .b_signed(b_sg),
    .prod(prod)
  );

  always_comb begin
    acc_old = (op_dst_b && op_code != alu_pkg::OP_DPSTEP) ?
              acc_b_ff : acc_a_ff;
    // Fractional product: one left shift, sign extended to 56 bits
    prod_ext = {{(alu_pkg::ACC_W-2*W-1){prod[2*W+1]}}, prod[2*W-1:0],
                1'b0};
    // Sixteen bit operands sit in bits 23:8, so the true product is
    // prod >> 16; the low part must not fall into the gap byte
    prod_40 = {{(alu_pkg::ACC_W-2*W-1){prod[2*W+1]}},
               prod[2*W-1:alu_pkg::SHIFT_SIXTEEN], 1'b0};
    acc_40 = pack16(acc_old);
    addend = alu_pkg::ACC_RST;
    addend_40 = {N_W{1'b0}};
    if (acc_en) begin
      addend = acc_old;
      addend_40 = acc_40;
    end else if (shift_en) begin
      addend = 56'($signed(acc_old) >>> alu_pkg::SHIFT_NORMAL);
      addend_40 = N_W'($signed(acc_40) >>> alu_pkg::SHIFT_SIXTEEN);
    end
    sum_40 = addend_40 + prod_40;
    nxt_acc = addend + prod_ext;
    if (sixteen_active_ff) begin
      nxt_acc = unpack16(sum_40) & alu_pkg::SIXTEEN_MASK;
    end
  end

  // ****************************************************
  // Input registers: bus writes
  // ****************************************************
  assign nxt_x = wr_word(x_data_bus, sixteen_active_ff);
  assign nxt_y = wr_word(y_data_bus, sixteen_active_ff);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      x0_ff <= alu_pkg::WORD_RST;
      x1_ff <= alu_pkg::WORD_RST;
      shared_operand_reg_ff <= alu_pkg::WORD_RST;
      y1_ff <= alu_pkg::WORD_RST;
    end else if (move_wr) begin
      case (move_wr_reg)
        alu_pkg::R_X0: x0_ff <= nxt_x;
        alu_pkg::R_X1: x1_ff <= nxt_x;
        alu_pkg::R_Y0: shared_operand_reg_ff <= nxt_x;
        alu_pkg::R_Y1: y1_ff <= nxt_x;
        alu_pkg::R_X: begin
          x1_ff <= nxt_x;
          x0_ff <= nxt_y;
        end
        alu_pkg::R_Y: begin
          y1_ff <= nxt_x;
          shared_operand_reg_ff <= nxt_y;
        end
        default: ;
      endcase
    end
  end

  // ****************************************************
  // Accumulators: bus writes, then operation results win
  // ****************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      acc_a_ff <= alu_pkg::ACC_RST;
      acc_b_ff <= alu_pkg::ACC_RST;
    end else begin
      if (move_wr) begin
        case (move_wr_reg)
          alu_pkg::R_A0: acc_a_ff[23:0] <= wr_word(x_data_bus,
                                                   sixteen_active_ff);
          alu_pkg::R_A1: acc_a_ff[47:24] <= wr_word(x_data_bus,
                                                    sixteen_active_ff);
          alu_pkg::R_A2: acc_a_ff[55:48] <= x_data_bus[7:0];
          alu_pkg::R_B0: acc_b_ff[23:0] <= wr_word(x_data_bus,
                                                   sixteen_active_ff);
          alu_pkg::R_B1: acc_b_ff[47:24] <= wr_word(x_data_bus,
                                                    sixteen_active_ff);
          alu_pkg::R_B2: acc_b_ff[55:48] <= x_data_bus[7:0];
          alu_pkg::R_A10: acc_a_ff[47:0] <= {
            wr_word(x_data_bus, sixteen_active_ff),
            wr_word(y_data_bus, sixteen_active_ff)};
          alu_pkg::R_B10: acc_b_ff[47:0] <= {
            wr_word(x_data_bus, sixteen_active_ff),
            wr_word(y_data_bus, sixteen_active_ff)};
          alu_pkg::R_A: acc_a_ff <= sixteen_active_ff ?
            {{24{x_data_bus[15]}}, x_data_bus[15:0], 16'h0000} :
            {{8{x_data_bus[23]}}, x_data_bus, 24'h000000};
          alu_pkg::R_B: acc_b_ff <= sixteen_active_ff ?
            {{24{x_data_bus[15]}}, x_data_bus[15:0], 16'h0000} :
            {{8{x_data_bus[23]}}, x_data_bus, 24'h000000};
          default: ;
        endcase
      end
      if (op_go && !(op_dst_b && op_code != alu_pkg::OP_DPSTEP)) begin
        acc_a_ff <= nxt_acc;
      end
      if (op_go && op_dst_b && op_code != alu_pkg::OP_DPSTEP) begin
        acc_b_ff <= nxt_acc;
      end
    end
  end

  // ****************************************************
  // Bus reads; scaling and limiting are not modelled here
  // ****************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      x_bus_out_ff <= alu_pkg::WORD_RST;
      y_bus_out_ff <= alu_pkg::WORD_RST;
    end else if (move_rd) begin
      y_bus_out_ff <= alu_pkg::WORD_RST;
      case (move_rd_reg)
        alu_pkg::R_X0: x_bus_out_ff <= rd_word(x0_ff, sixteen_active_ff);
        alu_pkg::R_X1: x_bus_out_ff <= rd_word(x1_ff, sixteen_active_ff);
        alu_pkg::R_Y0: x_bus_out_ff <= rd_word(shared_operand_reg_ff,
                                               sixteen_active_ff);
        alu_pkg::R_Y1: x_bus_out_ff <= rd_word(y1_ff, sixteen_active_ff);
        alu_pkg::R_A0: x_bus_out_ff <= rd_word(acc_a_ff[23:0],
                                               sixteen_active_ff);
        alu_pkg::R_A1: x_bus_out_ff <= rd_word(acc_a_ff[47:24],
                                               sixteen_active_ff);
        alu_pkg::R_A2: x_bus_out_ff <= {{16{acc_a_ff[55]}}, acc_a_ff[55:48]};
        alu_pkg::R_B0: x_bus_out_ff <= rd_word(acc_b_ff[23:0],
                                               sixteen_active_ff);
        alu_pkg::R_B1: x_bus_out_ff <= rd_word(acc_b_ff[47:24],
                                               sixteen_active_ff);
        alu_pkg::R_B2: x_bus_out_ff <= {{16{acc_b_ff[55]}}, acc_b_ff[55:48]};
        alu_pkg::R_A: x_bus_out_ff <= sixteen_active_ff ?
          {{8{acc_a_ff[47]}}, acc_a_ff[47:32]} : acc_a_ff[47:24];
        alu_pkg::R_B: x_bus_out_ff <= sixteen_active_ff ?
          {{8{acc_b_ff[47]}}, acc_b_ff[47:32]} : acc_b_ff[47:24];
        alu_pkg::R_X: begin
          x_bus_out_ff <= rd_word(x1_ff, sixteen_active_ff);
          y_bus_out_ff <= rd_word(x0_ff, sixteen_active_ff);
        end
        alu_pkg::R_Y: begin
          x_bus_out_ff <= rd_word(y1_ff, sixteen_active_ff);
          y_bus_out_ff <= rd_word(shared_operand_reg_ff, sixteen_active_ff);
        end
        alu_pkg::R_A10: begin
          x_bus_out_ff <= rd_word(acc_a_ff[47:24], sixteen_active_ff);
          y_bus_out_ff <= rd_word(acc_a_ff[23:0], sixteen_active_ff);
        end
        default: begin
          x_bus_out_ff <= rd_word(acc_b_ff[47:24], sixteen_active_ff);
          y_bus_out_ff <= rd_word(acc_b_ff[23:0], sixteen_active_ff);
        end
      endcase
    end
  end

  // ****************************************************
  // Sticky growth flag; a new event beats a same-cycle clear
  // ****************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      growth_flag_ff <= 1'b0;
    end else if (move_rd && ((move_rd_reg == alu_pkg::R_A &&
        grows(acc_a_ff)) || (move_rd_reg == alu_pkg::R_B &&
        grows(acc_b_ff)))) begin
      growth_flag_ff <= 1'b1;
    end else if (growth_clr) begin
      growth_flag_ff <= 1'b0;
    end
  end
endmodule // data_alu

/* sim/data_alu_assertions.sv */
/*
 * Checker on data_alu ports: mode lag, refusals, growth flag, masking.
 * Assumes alu_pkg is compiled first and the bind below attaches it.
 */
`timescale 1ns/10ps
module data_alu_assertions #(
  parameter int W = 24
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [alu_pkg::SR_W-1:0] status_register,
  input wire logic growth_clr,
  input wire alu_pkg::op_type op_code,
  input wire logic op_dst_b,
  input wire logic move_wr,
  input wire logic move_rd,
  input wire alu_pkg::reg_type move_rd_reg,
  input wire logic growth_flag_ff,
  input wire logic dpm_active_ff,
  input wire logic sixteen_active_ff,
  input wire logic [alu_pkg::ACC_W-1:0] acc_a_ff,
  input wire logic [alu_pkg::ACC_W-1:0] acc_b_ff
);
  // ************
  // Helpers
  // ************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic grow_a;
  logic grow_b;
  logic mul_op;
  logic dpm_bit;
  logic six_bit;
  assign grow_a = (acc_a_ff[46] ^ acc_a_ff[47]) |
    (acc_a_ff[45] ^ acc_a_ff[47]);
  assign grow_b = (acc_b_ff[46] ^ acc_b_ff[47]) |
    (acc_b_ff[45] ^ acc_b_ff[47]);
  assign mul_op = op_code inside {alu_pkg::OP_MPY, alu_pkg::OP_MAC,
    alu_pkg::OP_SHMAC};
  assign dpm_bit = status_register[alu_pkg::SR_DPM_POS];
  assign six_bit = status_register[alu_pkg::SR_SIXTEEN_POS];
  // ************
  // Assertions
  // ************
  a_dpm_lag: assert property (
    $past(rst_b) |-> dpm_active_ff == $past(dpm_bit)
  ) else $error("precision mode not one cycle behind its bit");
  a_sixteen_lag: assert property (
    $past(rst_b) |-> sixteen_active_ff == $past(six_bit)
  ) else $error("sixteen bit mode not one cycle behind its bit");
  a_growth_set: assert property (
    move_rd && ((move_rd_reg == alu_pkg::R_A && grow_a) ||
      (move_rd_reg == alu_pkg::R_B && grow_b)) |=> growth_flag_ff
  ) else $error("growth flag not set by accumulator move");
  a_growth_sticky: assert property (
    growth_flag_ff && !growth_clr |=> growth_flag_ff
  ) else $error("growth flag dropped without clear");
  a_growth_cause: assert property (
    $rose(growth_flag_ff) |-> $past(move_rd)
  ) else $error("growth flag rose without a move");
  a_dpm_refuse: assert property (
    dpm_active_ff && mul_op && !move_wr |=>
      $stable(acc_a_ff) && $stable(acc_b_ff)
  ) else $error("plain multiply acted in precision mode");
  a_step_gated: assert property (
    op_code == alu_pkg::OP_DPSTEP && !move_wr &&
      !(dpm_active_ff && !sixteen_active_ff) |=> $stable(acc_a_ff)
  ) else $error("algorithm step acted outside the mode");
  a_step_keeps_b: assert property (
    op_code == alu_pkg::OP_DPSTEP && !move_wr |=> $stable(acc_b_ff)
  ) else $error("algorithm step touched accumulator B");
  a_sixteen_mask: assert property (
    sixteen_active_ff && !dpm_active_ff && mul_op && !op_dst_b |=>
      (acc_a_ff & ~alu_pkg::SIXTEEN_MASK) == '0
  ) else $error("sixteen bit result has low byte bits set");
  c_step: cover property (dpm_active_ff && op_code == alu_pkg::OP_DPSTEP);
  c_growth: cover property ($rose(growth_flag_ff));
  c_sixteen: cover property (sixteen_active_ff && mul_op);
endmodule // data_alu_assertions

bind data_alu data_alu_assertions #(.W(W)) u_data_alu_assertions (
  .clk_sys(clk_sys), .rst_b(rst_b), .status_register(status_register),
  .growth_clr(growth_clr), .op_code(op_code), .op_dst_b(op_dst_b),
  .move_wr(move_wr), .move_rd(move_rd), .move_rd_reg(move_rd_reg),
  .growth_flag_ff(growth_flag_ff), .dpm_active_ff(dpm_active_ff),
  .sixteen_active_ff(sixteen_active_ff), .acc_a_ff(acc_a_ff),
  .acc_b_ff(acc_b_ff));

/* sim/mode_sequencer.sv */
/*
 * Sequencer side model: owns the status mode bits, raises mode_busy
 * while a mode switch settles.
 * Assumes the bench asks for modes by level and waits on mode_busy.
 */
`timescale 1ns/10ps
module mode_sequencer (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic want_dpm,
  input wire logic want_sixteen,
  output logic [alu_pkg::SR_W-1:0] status_word,
  output logic mode_busy
);
  // ************
  // Mode bits and settling guard
  // ************
  logic [alu_pkg::SR_W-1:0] mode_bits_ff = 24'h000000;
  logic [1:0] quiet_cnt_ff = 2'h0;
  assign status_word = mode_bits_ff;
  assign mode_busy = (quiet_cnt_ff != 2'h0);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode_bits_ff <= 24'h000000;
    end else begin
      mode_bits_ff[alu_pkg::SR_DPM_POS] <= want_dpm;
      mode_bits_ff[alu_pkg::SR_SIXTEEN_POS] <= want_sixteen;
    end
  end
  // Width switch needs two idle cycles, precision switch one
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      quiet_cnt_ff <= 2'h0;
    end else if (want_sixteen != mode_bits_ff[alu_pkg::SR_SIXTEEN_POS]) begin
      quiet_cnt_ff <= 2'h2;
    end else if (want_dpm != mode_bits_ff[alu_pkg::SR_DPM_POS]) begin
      quiet_cnt_ff <= 2'h1;
    end else if (mode_busy) begin
      quiet_cnt_ff <= quiet_cnt_ff - 2'h1;
    end
  end
endmodule // mode_sequencer

/* sim/dsp_data_alu_precision_modes_tb.sv */
/*
 * Bench for data_alu: sign forms, shifted accumulate, precision steps,
 * growth flag and sixteen bit mode.
 * Assumes alu_pkg, data_alu, the checker and mode_sequencer exist.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module dsp_data_alu_precision_modes_tb;
  // ************
  // Signals and instances
  // ************
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic growth_clr = 1'b0;
  alu_pkg::op_type op_code = alu_pkg::OP_NOP;
  alu_pkg::sign_type op_sign = alu_pkg::SG_SS;
  logic [1:0] op_src1 = 2'h0;
  logic [1:0] op_src2 = 2'h0;
  logic op_dst_b = 1'b0;
  logic [1:0] dp_step = 2'h0;
  logic move_wr = 1'b0;
  logic move_rd = 1'b0;
  alu_pkg::reg_type wr_reg = alu_pkg::R_X;
  alu_pkg::reg_type rd_reg = alu_pkg::R_A;
  logic [23:0] xd = 24'h000000;
  logic [23:0] yd = 24'h000000;
  logic want_dpm = 1'b0;
  logic want_sixteen = 1'b0;
  logic [23:0] sr, xo, yo;
  logic grow, dpm_on, six_on, busy;
  logic [55:0] acc_a, acc_b, ea, eb;
  int n_fail = 0;
  int check_count = 0;
  data_alu #(.W(24)) u_data_alu (.clk_sys(clk_sys), .rst_b(rst_b),
    .status_register(sr), .growth_clr(growth_clr), .op_code(op_code),
    .op_sign(op_sign), .op_src1(op_src1), .op_src2(op_src2),
    .op_dst_b(op_dst_b), .dp_step(dp_step), .move_wr(move_wr),
    .move_wr_reg(wr_reg), .x_data_bus(xd), .y_data_bus(yd),
    .move_rd(move_rd), .move_rd_reg(rd_reg), .x_bus_out_ff(xo),
    .y_bus_out_ff(yo), .growth_flag_ff(grow), .dpm_active_ff(dpm_on),
    .sixteen_active_ff(six_on), .acc_a_ff(acc_a), .acc_b_ff(acc_b));
  mode_sequencer u_mode_sequencer (.clk_sys(clk_sys), .rst_b(rst_b),
    .want_dpm(want_dpm), .want_sixteen(want_sixteen),
    .status_word(sr), .mode_busy(busy));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ************
  // Reference and bus tasks
  // ************
  function automatic logic [55:0] mul_ref(input logic [23:0] a,
    input logic [23:0] b, input alu_pkg::sign_type s);
    logic signed [25:0] sa;
    logic signed [25:0] sb;
    logic signed [55:0] p;
    sa = (s == alu_pkg::SG_UU) ? {2'b00, a} : {{2{a[23]}}, a};
    sb = (s == alu_pkg::SG_SS) ? {{2{b[23]}}, b} : {2'b00, b};
    p = sa * sb;
    return p <<< 1;
  endfunction
  function automatic logic [55:0] asr(input logic [55:0] v);
    logic signed [55:0] t;
    t = v;
    return t >>> 24;
  endfunction
  task automatic op(input alu_pkg::op_type c, input alu_pkg::sign_type s,
    input logic [1:0] a, input logic [1:0] b, input logic db,
    input logic [1:0] st);
    @(posedge clk_sys);
    op_code <= c;
    op_sign <= s;
    op_src1 <= a;
    op_src2 <= b;
    op_dst_b <= db;
    dp_step <= st;
    @(posedge clk_sys);
    op_code <= alu_pkg::OP_NOP;
    #1;
  endtask
  task automatic wr48(input alu_pkg::reg_type r, input logic [23:0] h,
    input logic [23:0] l);
    @(posedge clk_sys);
    move_wr <= 1'b1;
    wr_reg <= r;
    xd <= h;
    yd <= l;
    @(posedge clk_sys);
    move_wr <= 1'b0;
    xd <= ~h; // Released bus must not keep its last value
    yd <= ~l;
  endtask
  task automatic strobe(input logic en, input alu_pkg::reg_type r,
    input logic clr);
    @(posedge clk_sys);
    move_rd <= en;
    rd_reg <= r;
    growth_clr <= clr;
    @(posedge clk_sys);
    move_rd <= 1'b0;
    growth_clr <= 1'b0;
    #1;
  endtask
  task automatic mode(input logic d, input logic s);
    int i;
    @(posedge clk_sys);
    want_dpm <= d;
    want_sixteen <= s;
    @(posedge clk_sys);
    #1;
    i = 0;
    while (busy !== 1'b0 && i < 8) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    if (i == 8) begin
      n_fail++;
      final_report();
    end else begin
      `CHK("dpm_on", d, dpm_on)
      `CHK("six_on", s, six_on)
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ************
  // Scenarios
  // ************
  task automatic t_signs();
    alu_pkg::sign_type s;
    wr48(alu_pkg::R_X, 24'h400000, 24'h800000);
    wr48(alu_pkg::R_Y, 24'h123456, 24'hC00000);
    strobe(1'b1, alu_pkg::R_Y, 1'b0);
    `CHK("y_hi", 24'h123456, xo)
    `CHK("y_lo", 24'hC00000, yo)
    eb = acc_b;
    for (int k = 0; k < 3; k++) begin
      s = alu_pkg::sign_type'(k);
      op(alu_pkg::OP_MPY, s, 2'h0, 2'h2, 1'b0, 2'h0);
      `CHK("mpy", mul_ref(24'h800000, 24'hC00000, s), acc_a)
      op(alu_pkg::OP_MAC, s, 2'h1, 2'h2, 1'b1, 2'h0);
      eb = eb + mul_ref(24'h400000, 24'hC00000, s);
      `CHK("mac", eb, acc_b)
      ea = asr(acc_a) + mul_ref(24'h400000, 24'hC00000, s);
      op(alu_pkg::OP_SHMAC, s, 2'h1, 2'h2, 1'b0, 2'h0);
      `CHK("shmac", ea, acc_a)
    end
  endtask
  task automatic t_dpm();
    eb = acc_b;
    mode(1'b1, 1'b0);
    // Only the four steps run, shared operand untouched
    ea = mul_ref(24'h800000, 24'hC00000, alu_pkg::SG_UU);
    op(alu_pkg::OP_DPSTEP, alu_pkg::SG_SS, 2'h0, 2'h0, 1'b1, 2'h0);
    `CHK("step0", ea, acc_a)
    ea = asr(ea) + mul_ref(24'h400000, 24'hC00000, alu_pkg::SG_SU);
    op(alu_pkg::OP_DPSTEP, alu_pkg::SG_SS, 2'h0, 2'h0, 1'b1, 2'h1);
    `CHK("step1", ea, acc_a)
    ea = ea + mul_ref(24'h123456, 24'h800000, alu_pkg::SG_SU);
    op(alu_pkg::OP_DPSTEP, alu_pkg::SG_SS, 2'h0, 2'h0, 1'b1, 2'h2);
    `CHK("step2", ea, acc_a)
    ea = asr(ea) + mul_ref(24'h400000, 24'h123456, alu_pkg::SG_SS);
    op(alu_pkg::OP_DPSTEP, alu_pkg::SG_SS, 2'h0, 2'h0, 1'b1, 2'h3);
    `CHK("step3", ea, acc_a)
    `CHK("b_kept", eb, acc_b)
    op(alu_pkg::OP_MPY, alu_pkg::SG_SS, 2'h0, 2'h2, 1'b0, 2'h0);
    `CHK("mpy_in_dpm", ea, acc_a)
    mode(1'b0, 1'b0);
    op(alu_pkg::OP_DPSTEP, alu_pkg::SG_SS, 2'h0, 2'h0, 1'b0, 2'h0);
    `CHK("step_off", ea, acc_a)
  endtask
  task automatic t_growth();
    strobe(1'b0, alu_pkg::R_A, 1'b1);
    `CHK("g_clr", 1'b0, grow)
    op(alu_pkg::OP_MPY, alu_pkg::SG_SS, 2'h0, 2'h2, 1'b0, 2'h0);
    strobe(1'b1, alu_pkg::R_X, 1'b0);
    `CHK("g_reg", 1'b0, grow)
    strobe(1'b1, alu_pkg::R_A, 1'b0);
    `CHK("g_set", 1'b1, grow)
    op(alu_pkg::OP_MPY, alu_pkg::SG_SS, 2'h1, 2'h3, 1'b0, 2'h0);
    strobe(1'b1, alu_pkg::R_A, 1'b0);
    `CHK("g_stick", 1'b1, grow)
    strobe(1'b0, alu_pkg::R_A, 1'b1);
    strobe(1'b1, alu_pkg::R_A, 1'b0);
    `CHK("g_small", 1'b0, grow)
    op(alu_pkg::OP_MPY, alu_pkg::SG_SS, 2'h0, 2'h2, 1'b1, 2'h0);
    strobe(1'b1, alu_pkg::R_B, 1'b1);
    `CHK("g_set_b", 1'b1, grow)
  endtask
  task automatic t_sixteen();
    mode(1'b0, 1'b1);
    wr48(alu_pkg::R_X, 24'h004000, 24'h004000);
    strobe(1'b1, alu_pkg::R_X, 1'b0);
    `CHK("x16_hi", 24'h004000, xo)
    `CHK("x16_lo", 24'h004000, yo)
    wr48(alu_pkg::R_Y0, 24'h000001, 24'h000000);
    ea = mul_ref(24'h400000, 24'h123400, alu_pkg::SG_SS);
    op(alu_pkg::OP_MPY, alu_pkg::SG_SS, 2'h1, 2'h3, 1'b0, 2'h0);
    `CHK("mpy16", ea, acc_a)
    op(alu_pkg::OP_MAC, alu_pkg::SG_SS, 2'h1, 2'h3, 1'b0, 2'h0);
    `CHK("mac16", ea + ea, acc_a)
    op(alu_pkg::OP_SHMAC, alu_pkg::SG_SS, 2'h1, 2'h2, 1'b0, 2'h0);
    `CHK("dmac16", 56'h00000000923400, acc_a)
    mode(1'b0, 1'b0);
    op(alu_pkg::OP_MPY, alu_pkg::SG_SS, 2'h0, 2'h1, 1'b0, 2'h0);
    `CHK("after16", 56'h00200000000000, acc_a)
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    `CHK("acc_a_rst", alu_pkg::ACC_RST, acc_a)
    `CHK("acc_b_rst", alu_pkg::ACC_RST, acc_b)
    `CHK("grow_rst", 1'b0, grow)
    t_signs();
    t_dpm();
    t_growth();
    t_sixteen();
    final_report();
  end
endmodule // dsp_data_alu_precision_modes_tb
